// >>> hw/fsro_status_reg.sv
// Status register one of a serial flash with its command decode
//
// Operation
// - Bit 7 guard combines with hi bit, pin
// - Bit 5 selects bottom-up or top-down protection
// - Bits 4:2 extent, reset zero, unprotected
// - Extent written by direct status write command
// - Refuse program/erase into protected regions
// - Bit 1 latch; zero rejects write commands, except a status write after volatile enable
// - Latch cleared by power-up and reset
// - Aborted incomplete command keeps latch set
// - Complete write commands and write disable clear latch
// - Write-enable command sets the latch
// - Volatile enable leaves latch unset
// - Bit 0 busy while internal operation runs
// - Latch bit live; status write data never lands in it
// - Readable by 05h and 65h with 01h
// - Volatile write skips non-volatile copy update
`timescale 1ns/1ps

module fsro_status_reg (
   input wire logic clk,
   input wire logic rst,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   output logic so_out,
   output logic so_oe,
   input wire logic wp_n,
   input wire logic status_guard_hi,
   input wire logic region_locked,
   input wire logic op_done,
   output fsro_pkg::fsro_prot_type prot_cfg,
   output fsro_pkg::fsro_stat_type status,
   output logic [fsro_pkg::ADDR_W-1:0] target_addr,
   output fsro_pkg::fsro_op_req_type op_req
);
   import fsro_pkg::*;

   fsro_core_type core_r;
   fsro_core_type core_nxt;
   fsro_link_type link_r;
   fsro_link_type link_nxt;
   fsro_xfer_type xfer_r;
   fsro_xfer_type xfer_nxt;
   fsro_pin_type pin_r;
   fsro_pin_type pin_nxt;
   logic frame_rst;

   // ****************************************
   // Link side, serial clock domain
   // ****************************************

   // Deselect ends the frame at once
   assign frame_rst = rst | cs_n;

   always_comb begin
      logic [7:0] rx;
      rx = {link_r.shift, si};
      link_nxt = link_r;
      xfer_nxt = xfer_r;
      link_nxt.shift = rx[6:0];
      link_nxt.bit_idx = link_r.bit_idx + 3'h1;
      xfer_nxt.stat_s1 = core_r.stat;
      xfer_nxt.stat_s2 = xfer_r.stat_s1;
      if (link_r.bit_idx == BIT_LAST) begin
         xfer_nxt.byte_hold = rx;
         xfer_nxt.tgl = ~xfer_r.tgl;
         if (link_r.byte_no != BYTE_SAT) begin
            link_nxt.byte_no = link_r.byte_no + 2'h1;
         end
         if (link_r.byte_no == BYTE_OPCODE) begin
            link_nxt.op = rx;
            link_nxt.rd_active = (rx == OP_RD_STAT1);
         end
         if ((link_r.byte_no == BYTE_REG_ADDR) && (link_r.op == OP_RD_STAT_IND)) begin
            link_nxt.rd_active = (rx == REG_ADDR_STAT1);
         end
      end
   end

   always_ff @(posedge sck or posedge frame_rst) begin
      if (frame_rst) begin
         link_r <= '0;
      end else begin
         link_r <= link_nxt;
      end
   end

   // Byte handover and status sync survive deselect
   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         xfer_r <= '0;
      end else begin
         xfer_r <= xfer_nxt;
      end
   end

   // Output shifts on the falling edge, msb first
   always_comb begin
      pin_nxt.oe = link_r.rd_active;
      pin_nxt.so = link_r.rd_active & xfer_r.stat_s2[~link_r.bit_idx];
   end

   always_ff @(negedge sck or posedge frame_rst) begin
      if (frame_rst) begin
         pin_r <= '0;
      end else begin
         pin_r <= pin_nxt;
      end
   end

   assign so_out = pin_r.so;
   assign so_oe = pin_r.oe;

   // ****************************************
   // Command execution, system clock domain
   // ****************************************

   always_comb begin
      logic byte_evt;
      logic frame_start;
      logic frame_end;
      logic [7:0] rx_byte;
      logic [7:0] cmd;
      logic [2:0] len;
      logic is_erase;
      logic is_chip;
      logic prog_full;
      logic erase_full;
      logic chip_full;
      logic wr_full;
      logic wr_sel;
      logic wr_locked;
      fsro_stat_type wr_data;
      cmd = '0;
      len = LEN_NONE;
      is_erase = 1'b0;
      is_chip = 1'b0;
      prog_full = 1'b0;
      erase_full = 1'b0;
      chip_full = 1'b0;
      wr_full = 1'b0;
      wr_sel = 1'b0;
      wr_locked = 1'b0;
      wr_data = '0;
      byte_evt = core_r.tgl_s[2] ^ core_r.tgl_s[1];
      // Late cs tap lets the final byte land first
      frame_start = core_r.cs_s[CS_STAGES-1] & ~core_r.cs_s[CS_STAGES-2];
      frame_end = core_r.cs_s[CS_STAGES-2] & ~core_r.cs_s[CS_STAGES-1];
      rx_byte = xfer_r.byte_hold;
      core_nxt = core_r;
      core_nxt.req.valid = 1'b0;
      core_nxt.cs_s = {core_r.cs_s[CS_STAGES-2:0], cs_n};
      core_nxt.tgl_s = {core_r.tgl_s[1:0], xfer_r.tgl};
      core_nxt.wp_s = {core_r.wp_s[0], wp_n};

      if (frame_start) begin
         core_nxt.nbytes = LEN_NONE;
      end
      if (byte_evt) begin
         if (core_r.nbytes == LEN_NONE) begin
            core_nxt.cmd = rx_byte;
         end else if ((core_r.nbytes < LEN_ERASE) && !core_r.stat.busy_flag) begin
            core_nxt.addr = {core_r.addr[ADDR_W-BYTE_W-1:0], rx_byte};
         end
         if (core_r.nbytes != LEN_SAT) begin
            core_nxt.nbytes = core_r.nbytes + 3'h1;
         end
      end

      cmd = core_nxt.cmd;
      len = core_nxt.nbytes;
      is_erase = (cmd == OP_ERASE_4K) || (cmd == OP_ERASE_32K) || (cmd == OP_ERASE_64K) ||
                 (cmd == OP_ERASE_PAGE);
      is_chip = (cmd == OP_ERASE_CHIP) || (cmd == OP_ERASE_CHIP_ALT);
      prog_full = (cmd == OP_PROG) && (len >= LEN_PROG_MIN);
      erase_full = is_erase && (len == LEN_ERASE);
      chip_full = is_chip && (len == LEN_OPCODE);
      wr_full = ((cmd == OP_WR_STAT1) && (len == LEN_STAT_WR)) ||
                ((cmd == OP_WR_STAT_IND) && (len == LEN_STAT_WR_IND));
      wr_sel = (cmd == OP_WR_STAT1) || (core_nxt.addr[2*BYTE_W-1:BYTE_W] == REG_ADDR_STAT1);
      wr_data = fsro_stat_type'(core_nxt.addr[BYTE_W-1:0]);
      // guard with hi bit and pin
      wr_locked = status_guard_hi | (core_r.stat.status_guard_lo & ~core_r.wp_s[1]);

      if (op_done) begin
         core_nxt.stat.busy_flag = 1'b0;
      end

      // Commands are ignored while busy
      if (frame_end && !core_r.stat.busy_flag) begin
         if ((cmd == OP_WR_EN) && (len == LEN_OPCODE)) begin
            core_nxt.stat.write_permit_latch = 1'b1;
            core_nxt.vol_arm = 1'b0;
         end
         if ((cmd == OP_WR_DIS) && (len == LEN_OPCODE)) begin
            core_nxt.stat.write_permit_latch = 1'b0;
         end
         if ((cmd == OP_VOL_EN) && (len == LEN_OPCODE)) begin
            core_nxt.vol_arm = 1'b1;
         end

         if (wr_full) begin
            if ((core_r.stat.write_permit_latch | core_r.vol_arm) && !wr_locked && wr_sel) begin
               core_nxt.stat.protect_granule_select = wr_data.protect_granule_select;
               core_nxt.stat.protect_direction = wr_data.protect_direction;
               core_nxt.stat.protect_extent = wr_data.protect_extent;
               core_nxt.stat.status_guard_lo = wr_data.status_guard_lo;
               if (!core_r.vol_arm) begin
                  core_nxt.req.valid = 1'b1;
                  core_nxt.req.kind = OPK_NV_STATUS;
                  core_nxt.req.opcode = cmd;
                  core_nxt.req.nv_data = wr_data;
                  core_nxt.stat.busy_flag = 1'b1;
               end
            end
            core_nxt.vol_arm = 1'b0;
            core_nxt.stat.write_permit_latch = 1'b0;
         end

         if (prog_full || erase_full || chip_full) begin
            if (core_r.stat.write_permit_latch && !(region_locked && !chip_full) &&
                !(chip_full && (core_r.stat.protect_extent != EXTENT_NONE))) begin
               core_nxt.req.valid = 1'b1;
               core_nxt.req.kind = prog_full ? OPK_PROGRAM : OPK_ERASE;
               core_nxt.req.opcode = cmd;
               core_nxt.req.nv_data = '0;
               core_nxt.stat.busy_flag = 1'b1;
            end
            core_nxt.stat.write_permit_latch = 1'b0;
         end
         // anything else leaves the latch alone
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_r.stat <= fsro_stat_type'(STAT_RESET);
         core_r.vol_arm <= 1'b0;
         core_r.cmd <= '0;
         core_r.nbytes <= LEN_NONE;
         core_r.addr <= '0;
         core_r.cs_s <= CS_IDLE;
         core_r.tgl_s <= '0;
         core_r.wp_s <= '0;
         core_r.req <= '0;
      end else begin
         core_r <= core_nxt;
      end
   end

   // ****************************************
   // Outputs to the array and protection map
   // ****************************************

   assign prot_cfg.status_guard_lo = core_r.stat.status_guard_lo;
   assign prot_cfg.protect_granule_select = core_r.stat.protect_granule_select;
   assign prot_cfg.protect_direction = core_r.stat.protect_direction;
   assign prot_cfg.protect_extent = core_r.stat.protect_extent;
   assign status = core_r.stat;
   assign target_addr = core_r.addr;
   assign op_req = core_r.req;

   // ****************************************
   // Elaboration checks
   // ****************************************

   // Frame end taps two flops past the sync pair
   if (CS_STAGES < 4) begin : g_cs_stages_check
      $error("cs sync chain shorter than four flops");
   end

   // Address shifter collects exactly three bytes
   if (ADDR_W != 3 * BYTE_W) begin : g_addr_w_check
      $error("address width is not three bytes");
   end

   // Status image must be one byte
   if ($bits(fsro_stat_type) != BYTE_W) begin : g_stat_w_check
      $error("status image is not one byte");
   end

endmodule : fsro_status_reg

// >>> inc/fsro_pkg.sv
// Constants and types of the flash status register one block
package fsro_pkg;

   // ****************************************
   // Command opcodes
   // ****************************************
   localparam logic [7:0] OP_WR_STAT1 = 8'h01;
   localparam logic [7:0] OP_RD_STAT1 = 8'h05;
   localparam logic [7:0] OP_RD_STAT_IND = 8'h65;
   localparam logic [7:0] OP_WR_STAT_IND = 8'h71;
   localparam logic [7:0] OP_WR_EN = 8'h06;
   localparam logic [7:0] OP_WR_DIS = 8'h04;
   localparam logic [7:0] OP_VOL_EN = 8'h50;
   localparam logic [7:0] OP_PROG = 8'h02;
   localparam logic [7:0] OP_ERASE_4K = 8'h20;
   localparam logic [7:0] OP_ERASE_32K = 8'h52;
   localparam logic [7:0] OP_ERASE_64K = 8'hd8;
   localparam logic [7:0] OP_ERASE_PAGE = 8'h81;
   localparam logic [7:0] OP_ERASE_CHIP = 8'h60;
   localparam logic [7:0] OP_ERASE_CHIP_ALT = 8'hc7;
   localparam logic [7:0] REG_ADDR_STAT1 = 8'h01;

   // ****************************************
   // Widths, lengths and reset values
   // ****************************************
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned ADDR_W = 24;
   localparam int unsigned EXTENT_W = 3;
   localparam int unsigned CS_STAGES = 5;
   localparam logic [2:0] LEN_NONE = 3'h0;
   localparam logic [2:0] LEN_OPCODE = 3'h1;
   localparam logic [2:0] LEN_STAT_WR = 3'h2;
   localparam logic [2:0] LEN_STAT_WR_IND = 3'h3;
   localparam logic [2:0] LEN_ERASE = 3'h4;
   localparam logic [2:0] LEN_PROG_MIN = 3'h5;
   localparam logic [2:0] LEN_SAT = 3'h5;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] BYTE_OPCODE = 2'h0;
   localparam logic [1:0] BYTE_REG_ADDR = 2'h1;
   localparam logic [1:0] BYTE_SAT = 2'h3;
   localparam logic [7:0] STAT_RESET = 8'h00;
   localparam logic [EXTENT_W-1:0] EXTENT_NONE = 3'h0;
   localparam logic [CS_STAGES-1:0] CS_IDLE = 5'h1f;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      OPK_NONE = 2'b00,
      OPK_PROGRAM = 2'b01,
      OPK_ERASE = 2'b10,
      OPK_NV_STATUS = 2'b11
   } fsro_op_kind_type;

   // Field order gives bit 7 down to bit 0
   typedef struct packed {
      logic status_guard_lo;
      logic protect_granule_select;
      logic protect_direction;
      logic [EXTENT_W-1:0] protect_extent;
      logic write_permit_latch;
      logic busy_flag;
   } fsro_stat_type;

   typedef struct packed {
      logic status_guard_lo;
      logic protect_granule_select;
      logic protect_direction;
      logic [EXTENT_W-1:0] protect_extent;
   } fsro_prot_type;

   typedef struct packed {
      logic valid;
      fsro_op_kind_type kind;
      logic [7:0] opcode;
      logic [7:0] nv_data;
   } fsro_op_req_type;

   typedef struct packed {
      fsro_stat_type stat;
      logic vol_arm;
      logic [7:0] cmd;
      logic [2:0] nbytes;
      logic [ADDR_W-1:0] addr;
      logic [CS_STAGES-1:0] cs_s;
      logic [2:0] tgl_s;
      logic [1:0] wp_s;
      fsro_op_req_type req;
   } fsro_core_type;

   typedef struct packed {
      logic [2:0] bit_idx;
      logic [1:0] byte_no;
      logic [6:0] shift;
      logic [7:0] op;
      logic rd_active;
   } fsro_link_type;

   typedef struct packed {
      logic [7:0] byte_hold;
      logic tgl;
      logic [7:0] stat_s1;
      logic [7:0] stat_s2;
   } fsro_xfer_type;

   typedef struct packed {
      logic so;
      logic oe;
   } fsro_pin_type;

endpackage : fsro_pkg

// >>> verification/fsro_host.sv
// Serial host model issuing command frames
`timescale 1ns/1ps
module fsro_host (
   output logic sck,
   output logic cs_n,
   output logic si,
   input wire logic so_out
);
   logic [7:0] rd;
   event got;
   int gap;
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
      gap = 0;
   end
   task automatic frame(input logic [7:0] b [5], input int n, input int nrd);
      cs_n = 1'b0;
      for (int i = 0; i < n + nrd; i++) begin
         #(gap);
         for (int k = 7; k >= 0; k--) begin
            si = (i < n) ? b[i][k] : ~si;
            #62.5 sck = 1'b1;
            rd = {rd[6:0], so_out};
            #62.5 sck = 1'b0;
         end
      end
      if (nrd > 0) ->got;
      #62.5 cs_n = 1'b1;
      si = ~si;
      #250;
   endtask : frame
endmodule : fsro_host

// >>> verification/fsro_status_reg_sva.sv
// Port checker of status register one
`timescale 1ns/1ps
module fsro_status_reg_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic so_oe,
   input wire logic region_locked,
   input wire logic op_done,
   input wire fsro_pkg::fsro_prot_type prot_cfg,
   input wire fsro_pkg::fsro_stat_type status,
   input wire logic [fsro_pkg::ADDR_W-1:0] target_addr,
   input wire fsro_pkg::fsro_op_req_type op_req
);
   import fsro_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   AST_MIRROR: assert property (status[7:2] == prot_cfg)
      else $error("field copy differs");
   AST_CHANGE_AT_END: assert property (($changed(status[7:1]) || $rose(status.busy_flag)) |-> cs_n)
      else $error("status moved inside frame");
   AST_REQ_BUSY: assert property (op_req.valid |-> ##[0:1] status.busy_flag)
      else $error("busy not set at launch");
   AST_DONE_CLEARS: assert property (op_done && status.busy_flag |=> !status.busy_flag)
      else $error("busy kept after done");
   AST_LAUNCH_LATCH: assert property ($rose(status.busy_flag) |->
      $past(status.write_permit_latch) || $past(status.write_permit_latch, 2))
      else $error("launch without latch");
   AST_REQ_CLEARS: assert property (op_req.valid |-> ##[0:1] !status.write_permit_latch)
      else $error("latch kept after write");
   AST_REQ_PULSE: assert property (op_req.valid |=> !op_req.valid)
      else $error("request longer than a cycle");
   AST_NO_LOCKED: assert property (op_req.valid && (op_req.kind != OPK_NV_STATUS) &&
      (op_req.opcode != OP_ERASE_CHIP) && (op_req.opcode != OP_ERASE_CHIP_ALT) |-> !$past(region_locked))
      else $error("locked region launched");
   AST_FIELDS_IDLE: assert property ($changed(status[7:2]) |-> !$past(status.busy_flag))
      else $error("fields written while busy");
   AST_ADDR_FROZEN: assert property (status.busy_flag && $past(status.busy_flag) |-> $stable(target_addr))
      else $error("address moved while busy");
   AST_SO_QUIET: assert property (cs_n |-> !so_oe)
      else $error("output driven while deselected");
endmodule : fsro_status_reg_chk

// >>> verification/tb.sv
// Testbench of status register one
`timescale 1ns/1ps
module tb;
   import fsro_pkg::*;
   logic clk = 1'b0;
   logic rst, sck, cs_n, si, so_out, so_oe, wp_n, status_guard_hi, region_locked, op_done;
   fsro_prot_type prot_cfg;
   fsro_stat_type status;
   logic [ADDR_W-1:0] target_addr;
   fsro_op_req_type op_req;
   int fails = 0;
   int comparisons = 0;
   int seed = 32'h398c;
   logic [7:0] st, dd;
   logic [23:0] adr;
   logic [7:0] rq[$];
   logic [17:0] oq[$];
   logic [7:0] ops [6] = '{OP_ERASE_4K, OP_PROG, OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K, OP_ERASE_PAGE};
   always #5 clk = ~clk;
   fsro_status_reg fsro_status_reg_i (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
      .so_out(so_out), .so_oe(so_oe), .wp_n(wp_n), .status_guard_hi(status_guard_hi),
      .region_locked(region_locked), .op_done(op_done), .prot_cfg(prot_cfg), .status(status),
      .target_addr(target_addr), .op_req(op_req));
   fsro_host fsro_host_i (.sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out));
   task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic conclude();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude
   task automatic cmd(input logic [7:0] op, input logic [7:0] d, input int n);
      fsro_host_i.frame('{op, d, 8'h00, 8'h00, 8'h00}, n, 1'b0);
   endtask : cmd
   task automatic rd_stat(input bit ind);
      rq.push_back(st);
      if (ind) fsro_host_i.frame('{OP_RD_STAT_IND, REG_ADDR_STAT1, 8'h00, 8'h00, 8'h00}, 2, 1'b1);
      else fsro_host_i.frame('{OP_RD_STAT1, 8'h00, 8'h00, 8'h00, 8'h00}, 1, 1'b1);
   endtask : rd_stat
   task automatic done();
      @(negedge clk) op_done = 1'b1;
      @(negedge clk) op_done = 1'b0;
      st[0] = 1'b0;
   endtask : done
   always @(fsro_host_i.got) begin
      check(fsro_host_i.rd, rq.pop_front(), "status");
   end
   always @(negedge clk) begin
      if (op_req.valid === 1'b1) begin
         check({op_req.kind, op_req.opcode, op_req.nv_data}, oq.pop_front(), "request");
      end
   end
   initial begin
      rst = 1'b1;
      wp_n = 1'b1;
      status_guard_hi = 1'b0;
      region_locked = 1'b0;
      op_done = 1'b0;
      st = STAT_RESET;
      repeat (4) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      repeat (4) @(negedge clk);
      rd_stat(1'b0);
      rd_stat(1'b1);
      cmd(OP_VOL_EN, 8'h00, 1);
      rd_stat(1'b0);
      dd = 8'($random(seed));
      cmd(OP_WR_STAT1, dd, 2);
      st[7:2] = dd[7:2];
      rd_stat(1'b1);
      cmd(OP_WR_STAT1, ~dd, 2);
      rd_stat(1'b0);
      cmd(OP_WR_EN, 8'h00, 1);
      st[1] = 1'b1;
      rd_stat(1'b0);
      cmd(OP_WR_STAT1, 8'h00, 1);
      cmd(8'hab, 8'h00, 1);
      rd_stat(1'b1);
      dd = 8'($random(seed));
      oq.push_back({OPK_NV_STATUS, OP_WR_STAT1, dd});
      cmd(OP_WR_STAT1, dd, 2);
      st = {dd[7:2], 2'b01};
      rd_stat(1'b0);
      done();
      rd_stat(1'b1);
      @(negedge clk) status_guard_hi = 1'b1;
      cmd(OP_VOL_EN, 8'h00, 1);
      cmd(OP_WR_STAT1, ~st, 2);
      rd_stat(1'b0);
      @(negedge clk) status_guard_hi = 1'b0;
      wp_n = 1'b0;
      // indirect write, locked only by low guard with pin
      cmd(OP_VOL_EN, 8'h00, 1);
      fsro_host_i.frame('{OP_WR_STAT_IND, REG_ADDR_STAT1, ~st, 8'h00, 8'h00}, 3, 0);
      if (!st[7]) st[7:2] = ~st[7:2];
      rd_stat(1'b1);
      @(negedge clk) wp_n = 1'b1;
      // latch set, then cleared by write disable
      cmd(OP_WR_EN, 8'h00, 1);
      st[1] = 1'b1;
      rd_stat(1'b1);
      cmd(OP_WR_DIS, 8'h00, 1);
      st[1] = 1'b0;
      rd_stat(1'b0);
      for (int i = 0; i < 6; i++) begin
         adr = 24'($random(seed));
         @(negedge clk) region_locked = (i == 0);
         fsro_host_i.gap = (i % 2) * 300;
         cmd(OP_WR_EN, 8'h00, 1);
         if (i > 0) oq.push_back({(ops[i] == OP_PROG) ? OPK_PROGRAM : OPK_ERASE, ops[i], 8'h00});
         fsro_host_i.frame('{ops[i], adr[23:16], adr[15:8], adr[7:0], dd}, (ops[i] == OP_PROG) ? 5 : 4, 1'b0);
         st[1] = 1'b0;
         st[0] = (i > 0);
         rd_stat(i[0]);
         if (i > 0) check(target_addr, adr, "address");
         if (i == 5) begin
            // busy falls inside one long polling read
            st[0] = 1'b0;
            rq.push_back(st);
            fork
               fsro_host_i.frame('{OP_RD_STAT1, 8'h00, 8'h00, 8'h00, 8'h00}, 1, 3);
               begin
                  #1500;
                  done();
               end
            join
         end else begin
            done();
         end
      end
      // chip erase ignores the map, needs zero extent
      @(negedge clk) region_locked = 1'b1;
      cmd(OP_WR_EN, 8'h00, 1);
      if (st[4:2] == EXTENT_NONE) oq.push_back({OPK_ERASE, OP_ERASE_CHIP, 8'h00});
      cmd(OP_ERASE_CHIP, 8'h00, 1);
      st[0] = (st[4:2] == EXTENT_NONE);
      rd_stat(1'b0);
      done();
      region_locked = 1'b0;
      rd_stat(1'b0);
      repeat (20) @(negedge clk);
      check(rq.size() + oq.size(), 0, "pending");
      conclude();
   end
   initial begin
      #400000;
      fails++;
      conclude();
   end
endmodule : tb
bind fsro_status_reg fsro_status_reg_chk fsro_status_reg_chk_i (.clk(clk), .rst(rst), .cs_n(cs_n),
   .so_oe(so_oe), .region_locked(region_locked), .op_done(op_done), .prot_cfg(prot_cfg),
   .status(status), .target_addr(target_addr), .op_req(op_req));
